/* core/four_level_interrupt_priority.sv */
// Four-level interrupt priority controller with AXI4-Lite register access
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module four_level_interrupt_priority
  import intprio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Request flags from the sources
  input wire logic [NSRC-1:0] request_flags,
  input wire logic ext0_transition_mode,
  input wire logic ext1_transition_mode,
  output logic [NSRC-1:0] flag_clear,
  // Processor core side
  output core_req_t core_req,
  input wire logic core_ack,
  input wire logic core_return,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Level of one source from its two priority bits
  function automatic logic [1:0] level_of(input logic [7:0] hi, input logic [7:0] lo, input logic [2:0] s);
    level_of = {hi[s], lo[s]};
  endfunction

  // Register index from a byte address
  function automatic logic [9:0] index_of(input logic [ADDR_W-1:0] a);
    index_of = a[ADDR_W-1:2];
  endfunction

  // Highest level set in the in-service record, with a valid flag
  function automatic logic [2:0] top_level(input logic [3:0] m);
    top_level = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        top_level = {1'b1, 2'(i)};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] enable_r, enable_nxt;
  logic [7:0] prio_high_r, prio_high_nxt;
  logic [7:0] prio_low_r, prio_low_nxt;
  logic [7:0] event_status_r, event_status_nxt;
  logic [7:0] event_mask_r, event_mask_nxt;
  logic aw_held_r, aw_held_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [7:0] w_data_r, w_data_nxt;
  logic w_lane_r, w_lane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  arb_state_t arb_r, arb_nxt;
  logic [3:0] in_service_r, in_service_nxt;
  logic [7:0] vector_r, vector_nxt;
  logic [1:0] offer_level_r, offer_level_nxt;
  logic [2:0] offer_src_r, offer_src_nxt;
  logic [NSRC-1:0] flag_clear_r, flag_clear_nxt;

  logic do_write, do_read, status_read;
  logic [NSRC-1:0] active;
  logic found;
  logic [2:0] best_src;
  logic [1:0] best_lvl;
  logic [2:0] cur_top;
  logic can_take;
  logic [7:0] ev_set;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Pending flags stay live until enabled and chosen
  assign active = request_flags & enable_r[NSRC-1:0]
                & {NSRC{enable_r[GLOBAL_ENABLE_BIT]}};

  // Scan in polling order; only a strictly higher level displaces
  always_comb begin
    found = 1'b0;
    best_src = 3'h0;
    best_lvl = 2'h0;
    for (int p = 0; p < NSRC; p++) begin
      if (active[POLL_ORDER[p]] &&
          (!found || level_of(prio_high_r, prio_low_r, POLL_ORDER[p]) > best_lvl)) begin
        found = 1'b1;
        best_src = POLL_ORDER[p];
        best_lvl = level_of(prio_high_r, prio_low_r, POLL_ORDER[p]);
      end
    end
  end

  // Serve only above the highest level in service
  assign cur_top = top_level(in_service_r);
  assign can_take = found && (!cur_top[2] || best_lvl > cur_top[1:0]);

  // Offer, vectoring and return bookkeeping
  always_comb begin
    arb_nxt = arb_r;
    in_service_nxt = in_service_r;
    vector_nxt = vector_r;
    offer_level_nxt = offer_level_r;
    offer_src_nxt = offer_src_r;
    flag_clear_nxt = '0;
    ev_set = 8'h00;
    // Return drops the highest level, exposing the preempted one
    if (core_return && cur_top[2]) begin
      in_service_nxt[cur_top[1:0]] = 1'b0;
      ev_set[EV_RETURN] = 1'b1;
    end
    case (arb_r)
      ARB_IDLE: begin
        if (can_take && !core_return) begin
          arb_nxt = ARB_OFFER;
          vector_nxt = VECTOR_TABLE[best_src];
          offer_level_nxt = best_lvl;
          offer_src_nxt = best_src;
        end
      end
      ARB_OFFER: begin
        if (core_ack) begin
          arb_nxt = ARB_IDLE;
          in_service_nxt[offer_level_r] = 1'b1;
          ev_set[EV_VECTORED] = 1'b1;
          ev_set[EV_NESTED] = cur_top[2];
          flag_clear_nxt[offer_src_r] = HW_CLEAR_ALWAYS[offer_src_r]
            | (offer_src_r == 3'(SRC_EXT0) && ext0_transition_mode)
            | (offer_src_r == 3'(SRC_EXT1) && ext1_transition_mode);
        end else if (!active[offer_src_r] || core_return || !can_take
                     || best_src != offer_src_r) begin
          // Withdraw a stale offer and arbitrate afresh
          arb_nxt = ARB_IDLE;
        end
      end
      default: begin
        arb_nxt = ARB_IDLE;
      end
    endcase
  end

  // Arbiter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arb_r <= ARB_IDLE;
      in_service_r <= 4'h0;
      vector_r <= 8'h00;
      offer_level_r <= 2'h0;
      offer_src_r <= 3'h0;
      flag_clear_r <= '0;
    end else begin
      arb_r <= arb_nxt;
      in_service_r <= in_service_nxt;
      vector_r <= vector_nxt;
      offer_level_r <= offer_level_nxt;
      offer_src_r <= offer_src_nxt;
      flag_clear_r <= flag_clear_nxt;
    end
  end

  assign core_req.valid = (arb_r == ARB_OFFER);
  assign core_req.vector = vector_r;
  assign core_req.level = offer_level_r;
  assign flag_clear = flag_clear_r;
  assign irq = |(event_status_r & event_mask_r);

  // ----------------------------------------------------------------
  // AXI4-Lite channels
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign do_read = s_axi_arvalid && !rvalid_r;
  assign status_read = do_read && index_of(s_axi_araddr) == IDX_EVENT_STATUS;

  // Address and data are held apart, then written together
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      case (index_of(aw_addr_r))
        IDX_ENABLE, IDX_PRIO_HIGH, IDX_PRIO_LOW, IDX_EVENT_STATUS, IDX_EVENT_MASK,
        IDX_CORE_STATUS: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (index_of(s_axi_araddr))
        IDX_ENABLE: rdata_nxt = {24'h0, enable_r};
        IDX_PRIO_HIGH: rdata_nxt = {24'h0, 1'b0, prio_high_r[6:0]};
        IDX_PRIO_LOW: rdata_nxt = {24'h0, 1'b0, prio_low_r[6:0]};
        IDX_EVENT_STATUS: rdata_nxt = {24'h0, event_status_r};
        IDX_EVENT_MASK: rdata_nxt = {24'h0, event_mask_r};
        IDX_CORE_STATUS: rdata_nxt = {27'h0, (arb_r == ARB_OFFER), in_service_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Software writes on lane 0; status clears on read, new events win
  always_comb begin
    enable_nxt = enable_r;
    prio_high_nxt = prio_high_r;
    prio_low_nxt = prio_low_r;
    event_mask_nxt = event_mask_r;
    event_status_nxt = event_status_r;
    if (status_read) begin
      event_status_nxt = 8'h00;
    end
    if (do_write && w_lane_r) begin
      case (index_of(aw_addr_r))
        IDX_ENABLE: enable_nxt = w_data_r;
        IDX_PRIO_HIGH: prio_high_nxt = {1'b0, w_data_r[6:0]};
        IDX_PRIO_LOW: prio_low_nxt = {1'b0, w_data_r[6:0]};
        IDX_EVENT_MASK: event_mask_nxt = w_data_r;
        default: begin
        end
      endcase
    end
    event_status_nxt = event_status_nxt | ev_set;
  end

  // Software register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= RESET_ENABLE;
      prio_high_r <= RESET_PRIO;
      prio_low_r <= RESET_PRIO;
      event_status_r <= RESET_EVENT;
      event_mask_r <= RESET_EVENT;
    end else begin
      enable_r <= enable_nxt;
      prio_high_r <= prio_high_nxt;
      prio_low_r <= prio_low_nxt;
      event_status_r <= event_status_nxt;
      event_mask_r <= event_mask_nxt;
    end
  end

endmodule

/* core/intprio_pkg.sv */
// Constants, types and register map of the four-level interrupt priority block
package intprio_pkg;

  // ----------------------------------------------------------------
  // Sources and register map
  // ----------------------------------------------------------------
  localparam int NSRC = 7;
  localparam int ADDR_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_ENABLE = 10'h0a8;
  localparam logic [9:0] IDX_PRIO_HIGH = 10'h0b7;
  localparam logic [9:0] IDX_PRIO_LOW = 10'h0b8;
  localparam logic [9:0] IDX_EVENT_STATUS = 10'h0c0;
  localparam logic [9:0] IDX_EVENT_MASK = 10'h0c1;
  localparam logic [9:0] IDX_CORE_STATUS = 10'h0c2;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_PRIO = 8'h00;
  localparam logic [7:0] RESET_EVENT = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TIMER0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TIMER1 = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_TIMER2 = 5;
  localparam int SRC_COUNTER_ARRAY = 6;
  localparam int EV_VECTORED = 0;
  localparam int EV_NESTED = 1;
  localparam int EV_RETURN = 2;
  localparam int CORE_OFFER_BIT = 4;

  // Vector address per source, indexed by enable bit position
  localparam logic [NSRC-1:0][7:0] VECTOR_TABLE = {
    8'h33, 8'h2b, 8'h23, 8'h1b, 8'h13, 8'h0b, 8'h03};
  // Polling order, slot 0 first: ext0, t0, ext1, t1, array, serial, t2
  localparam logic [NSRC-1:0][2:0] POLL_ORDER = {
    3'h5, 3'h4, 3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
  // Sources whose request flag hardware always clears on vectoring
  localparam logic [NSRC-1:0] HW_CLEAR_ALWAYS = 7'h0a;

  // ----------------------------------------------------------------
  // Bus answers and carriers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    logic [1:0] level;
  } core_req_t;

  typedef enum logic [0:0] {
    ARB_IDLE = 1'b0,
    ARB_OFFER = 1'b1
  } arb_state_t;

endpackage

/* verification/core_source_model.sv */
// Processor core and request source model
`timescale 1ns/1ps
module core_source_model
  import intprio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NSRC-1:0] set_flags,
  input wire logic [NSRC-1:0] sw_clr,
  input wire logic ack_en,
  input wire logic [1:0] ack_wait,
  input wire logic [NSRC-1:0] flag_clear,
  input wire core_req_t core_req,
  output logic [NSRC-1:0] request_flags,
  output logic core_ack,
  output logic [7:0] last_vec,
  output logic [1:0] last_lvl,
  output logic [7:0] taken
);
  // ----------------------------------------
  // Flags and acknowledge
  // ----------------------------------------
  logic [1:0] cnt_r;
  // Flags held here; ack rises ack_wait+1 cycles after the offer rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      request_flags <= '0;
      core_ack <= 1'b0;
      cnt_r <= 2'h0;
      taken <= 8'h00;
      last_vec <= 8'h00;
      last_lvl <= 2'h0;
    end else begin
      request_flags <= (request_flags & ~flag_clear & ~sw_clr) | set_flags;
      core_ack <= ack_en && core_req.valid && !core_ack && cnt_r == ack_wait;
      cnt_r <= (core_req.valid && !core_ack && cnt_r != ack_wait) ? cnt_r + 2'h1 : 2'h0;
      if (core_ack && core_req.valid) begin
        taken <= taken + 8'h01;
        last_vec <= core_req.vector;
        last_lvl <= core_req.level;
      end
    end
  end
endmodule

/* verification/four_level_interrupt_priority_assertions.sv */
// Port-level checks for the interrupt priority block
`timescale 1ns/1ps
module intprio_checker
  import intprio_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0] request_flags,
  input wire logic ext0_transition_mode,
  input wire logic [NSRC-1:0] flag_clear,
  input wire core_req_t core_req,
  input wire logic core_ack
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Accepted offer of a given vector
  sequence taken_s(logic [7:0] v);
    core_ack && core_req.valid && core_req.vector == v;
  endsequence
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  vector_legal_a: assert property (core_req.valid |-> core_req.vector inside {8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33})
    else $error("illegal vector offered");
  offer_cause_a: assert property ($rose(core_req.valid) |-> $past(|request_flags))
    else $error("offer without request");
  ext0_clear_a: assert property (taken_s(8'h03) ##0 ext0_transition_mode |=> flag_clear == 7'h01)
    else $error("edge ext0 flag not cleared");
  ext0_keep_a: assert property (taken_s(8'h03) ##0 !ext0_transition_mode |=> flag_clear == 7'h00)
    else $error("level ext0 flag cleared");
  timer0_clear_a: assert property (taken_s(8'h0b) |=> flag_clear == 7'h02)
    else $error("timer0 flag not cleared");
  soft_flags_a: assert property (flag_clear[6:4] == 3'h0)
    else $error("software-owned flag cleared");
  clear_cause_a: assert property (|flag_clear |-> $past(core_ack && core_req.valid))
    else $error("clear without vectoring");
  ack_drops_a: assert property (core_ack && core_req.valid |=> !core_req.valid)
    else $error("offer stands after ack");
  cover property (taken_s(8'h1b));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (taken_s(8'h03) ##0 !ext0_transition_mode);
endmodule

/* verification/four_level_interrupt_priority_tb.sv */
// Self-checking bench for the interrupt priority block
`timescale 1ns/1ps
module four_level_interrupt_priority_tb
  import intprio_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [11:0] ENA = {IDX_ENABLE, 2'h0};
  localparam logic [11:0] PH = {IDX_PRIO_HIGH, 2'h0};
  localparam logic [11:0] PL = {IDX_PRIO_LOW, 2'h0};
  localparam logic [11:0] STA = {IDX_EVENT_STATUS, 2'h0};
  localparam logic [11:0] MSK = {IDX_EVENT_MASK, 2'h0};
  localparam logic [11:0] COR = {IDX_CORE_STATUS, 2'h0};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, x0m, x1m, core_ack, core_return, irq, ack_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, ack_wait, last_lvl;
  logic [6:0] set_flags, sw_clr, request_flags, flag_clear;
  logic [7:0] last_vec, taken, t0;
  core_req_t core_req;
  int fail_count, compares;
  logic [7:0] vec_tab [7] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h33};
  logic [7:0] poll_vec [7] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h33, 8'h23, 8'h2b};
  int poll_src [7] = '{0, 1, 2, 3, 6, 4, 5};

  four_level_interrupt_priority four_level_interrupt_priority_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .request_flags(request_flags), .ext0_transition_mode(x0m),
    .ext1_transition_mode(x1m), .flag_clear(flag_clear), .core_req(core_req), .core_ack(core_ack),
    .core_return(core_return), .irq(irq));
  core_source_model core_source_model_inst (.aclk(aclk), .aresetn(aresetn), .set_flags(set_flags),
    .sw_clr(sw_clr), .ack_en(ack_en), .ack_wait(ack_wait), .flag_clear(flag_clear), .core_req(core_req),
    .request_flags(request_flags), .core_ack(core_ack), .last_vec(last_vec), .last_lvl(last_lvl),
    .taken(taken));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_of_test;
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      @(posedge aclk);
      awvalid <= aw;
      wvalid <= w;
    end
    do @(negedge aclk); while (!bvalid);
    chk(bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    chk(rdata, {24'h0, e});
    chk(rresp, er);
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Raise flags, clear flags and signal a handler return for one cycle
  task ev(input logic [6:0] s, input logic [6:0] c, input logic r);
    @(posedge aclk);
    set_flags <= s;
    sw_clr <= c;
    core_return <= r;
    @(posedge aclk);
    set_flags <= 7'h00;
    sw_clr <= 7'h00;
    core_return <= 1'b0;
  endtask
  task take(input logic [7:0] e);
    t0 = taken;
    do @(negedge aclk); while (taken == t0);
    chk(last_vec, e);
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_of_test();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, core_return} <= '0;
    {awaddr, araddr, wdata, set_flags, sw_clr} <= '0;
    ack_en <= 1'b1;
    ack_wait <= 2'h0;
    x0m <= 1'b1;
    x1m <= 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ENA, 8'h00, RESP_OKAY);
    rd(PL, 8'h00, RESP_OKAY);
    wr(PH, 8'hff, RESP_OKAY);
    rd(PH, 8'h7f, RESP_OKAY);
    wr(PH, 8'h00, RESP_OKAY);
    wr(12'h100, 8'h55, RESP_SLVERR);
    rd(12'h100, 8'h00, RESP_SLVERR);
    // Global enable off holds the request, then it is served
    wr(ENA, 8'h7f, RESP_OKAY);
    ev(7'h01, 7'h00, 1'b0);
    repeat (6) @(posedge aclk);
    chk(taken, 8'h00);
    wr(ENA, 8'h81, RESP_OKAY);
    take(8'h03);
    repeat (3) @(posedge aclk);
    chk(request_flags, 7'h00);
    ev(7'h00, 7'h00, 1'b1);
    // Each source alone: vector, enable bit and flag clearing, both externals level-activated
    x0m <= 1'b0;
    x1m <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      ack_wait <= 2'(i % 3);
      wr(ENA, 8'h80 | (8'h01 << i), RESP_OKAY);
      ev(7'h01 << i, 7'h00, 1'b0);
      take(vec_tab[i]);
      repeat (3) @(posedge aclk);
      chk(request_flags, (7'h01 << i) & 7'h75);
      ev(7'h00, 7'h7f, 1'b1);
    end
    // All at one level: polling order, one at a time
    ack_wait <= 2'h0;
    x1m <= 1'b1;
    ack_en <= 1'b0;
    wr(ENA, 8'hff, RESP_OKAY);
    ev(7'h7f, 7'h00, 1'b0);
    ack_en <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      take(poll_vec[k]);
      repeat (4) @(posedge aclk);
      chk(taken, t0 + 8'h01);
      ev(7'h00, 7'h01 << poll_src[k], 1'b1);
    end
    // Four levels: preemption and nesting record
    wr(PL, 8'h18, RESP_OKAY);
    wr(PH, 8'h0c, RESP_OKAY);
    ev(7'h10, 7'h00, 1'b0);
    take(8'h23);
    chk(last_lvl, 2'h1);
    ev(7'h20, 7'h00, 1'b0);
    rd(COR, 8'h02, RESP_OKAY);
    ev(7'h04, 7'h00, 1'b0);
    take(8'h13);
    chk(last_lvl, 2'h2);
    ev(7'h08, 7'h00, 1'b0);
    take(8'h1b);
    chk(last_lvl, 2'h3);
    rd(COR, 8'h0e, RESP_OKAY);
    ev(7'h00, 7'h00, 1'b1);
    rd(COR, 8'h06, RESP_OKAY);
    ev(7'h00, 7'h00, 1'b1);
    rd(COR, 8'h02, RESP_OKAY);
    ev(7'h00, 7'h10, 1'b1);
    take(8'h2b);
    chk(last_lvl, 2'h0);
    ev(7'h00, 7'h20, 1'b1);
    // Event status, mask and interrupt line
    wr(MSK, 8'h01, RESP_OKAY);
    chk(irq, 1'b1);
    rd(STA, 8'h07, RESP_OKAY);
    chk(irq, 1'b0);
    rd(STA, 8'h00, RESP_OKAY);
    // Reset in mid-run returns registers and nesting record to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ENA, 8'h00, RESP_OKAY);
    rd(PH, 8'h00, RESP_OKAY);
    rd(PL, 8'h00, RESP_OKAY);
    rd(COR, 8'h00, RESP_OKAY);
    end_of_test();
  end
endmodule

bind four_level_interrupt_priority intprio_checker intprio_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .request_flags(request_flags), .ext0_transition_mode(ext0_transition_mode),
  .flag_clear(flag_clear), .core_req(core_req), .core_ack(core_ack));
